// ==== src/fg_flash_access_guard.sv ====
`timescale 1ns/10ps
module fg_flash_access_guard
  import fg_pkg::*;
(
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              reset_n,
  // Special function register port
  input  wire logic [7:0]        sfr_addr,
  input  wire logic              sfr_wr_en,
  input  wire logic              sfr_rd_en,
  input  wire logic [7:0]        sfr_wdata,
  output logic      [7:0]        sfr_rdata,
  // Flash access request
  input  wire logic              req_valid,
  input  wire fg_src_type        req_src,
  input  wire fg_op_type         req_op,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [ADDR_W-1:0] req_exec_addr,
  input  wire logic [DATA_W-1:0] req_wdata,
  // Security bytes held in flash
  input  wire logic [7:0]        read_lock_byte,
  input  wire logic [7:0]        write_lock_byte,
  // Flash read return
  input  wire logic              flash_rvalid,
  input  wire logic [DATA_W-1:0] flash_rdata,
  // Request answer
  output logic                   req_done,
  output logic                   req_denied,
  output logic                   resp_valid,
  output logic      [DATA_W-1:0] resp_data,
  // Flash command
  output logic                   flash_cmd_valid,
  output fg_cmd_type             flash_cmd,
  output logic      [ADDR_W-1:0] flash_addr,
  output logic      [DATA_W-1:0] flash_wdata,
  output logic                   flash_scratch,
  output logic      [1:0]        read_time_code
);

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic [7:0]        timing_we_q;
  logic [7:0]        timing_we_d;
  logic [7:0]        prog_store_q;
  logic [7:0]        prog_store_d;
  logic [7:0]        limit_byte_q;
  logic [7:0]        limit_byte_d;
  logic              limit_locked_q;
  logic              limit_locked_d;
  logic [7:0]        sfr_rdata_q;
  logic [7:0]        sfr_rdata_d;

  // ----------------------------------------
  // Answer state
  // ----------------------------------------
  logic              req_done_q;
  logic              req_denied_q;
  logic              resp_valid_q;
  logic              resp_valid_d;
  logic [DATA_W-1:0] resp_data_q;
  logic [DATA_W-1:0] resp_data_d;
  logic              cmd_valid_q;
  fg_cmd_type        cmd_q;
  logic [ADDR_W-1:0] cmd_addr_q;
  logic [DATA_W-1:0] cmd_wdata_q;
  logic              cmd_scratch_q;

  // ----------------------------------------
  // Register decode
  // ----------------------------------------
  logic              wr_timing;
  logic              wr_prog;
  logic              wr_limit;
  logic              global_write_permit;
  logic              scratchpad_select;
  logic              page_erase_enable;
  logic              program_write_enable;
  logic [ADDR_W-1:0] access_limit_address;

  assign wr_timing = sfr_wr_en && sfr_addr == TIMING_WE_OFS;
  assign wr_prog   = sfr_wr_en && sfr_addr == PROG_STORE_OFS;
  assign wr_limit  = sfr_wr_en && sfr_addr == ACCESS_LIMIT_OFS;

  assign global_write_permit  = timing_we_q[GWP_BIT];
  assign scratchpad_select    = prog_store_q[SPS_BIT];
  assign page_erase_enable    = prog_store_q[PEE_BIT];
  assign program_write_enable = prog_store_q[PWE_BIT];

  // Low bits of the limit are fixed at zero
  assign access_limit_address =
    {limit_byte_q, {LIMIT_SHIFT{1'b0}}};

  // Reserved bits are dropped on write so they read zero
  assign timing_we_d = wr_timing ?
    (sfr_wdata & TIMING_WE_MASK) : timing_we_q;
  assign prog_store_d = wr_prog ?
    (sfr_wdata & PROG_STORE_MASK) : prog_store_q;

  // Only the first write after reset sticks
  assign limit_byte_d = (wr_limit && !limit_locked_q) ?
    sfr_wdata : limit_byte_q;
  assign limit_locked_d = limit_locked_q || wr_limit;

  // Read mux; unmapped offsets read zero
  assign sfr_rdata_d =
    !sfr_rd_en                         ? sfr_rdata_q :
    (sfr_addr == TIMING_WE_OFS)        ? timing_we_q :
    (sfr_addr == PROG_STORE_OFS)       ? prog_store_q :
    (sfr_addr == ACCESS_LIMIT_OFS)     ? limit_byte_q :
                                         8'h00;

  // ----------------------------------------
  // Address classification
  // ----------------------------------------
  logic [2:0] tgt_block;
  logic       tgt_sec_page;
  logic       tgt_sec_byte;
  logic       tgt_reserved;
  logic       tgt_below;
  logic       exe_below;

  fg_addr_class #(
    .AW          (ADDR_W)
  ) u_tgt_class (
    .addr        (req_addr),
    .limit_addr  (access_limit_address),
    .block       (tgt_block),
    .sec_page    (tgt_sec_page),
    .sec_byte    (tgt_sec_byte),
    .reserved    (tgt_reserved),
    .below_limit (tgt_below)
  );

  fg_addr_class #(
    .AW          (ADDR_W)
  ) u_exe_class (
    .addr        (req_exec_addr),
    .limit_addr  (access_limit_address),
    .block       (),
    .sec_page    (),
    .sec_byte    (),
    .reserved    (),
    .below_limit (exe_below)
  );

  // ----------------------------------------
  // Debug port permissions
  // ----------------------------------------
  logic blk_read_open;
  logic blk_we_open;
  logic sec_we_open;
  logic dbg_read_ok;
  logic dbg_write_ok;
  logic dbg_erase_ok;
  logic dbg_full_erase;

  // A cleared lock bit closes its block
  assign blk_read_open = read_lock_byte[tgt_block];
  assign blk_we_open   = write_lock_byte[tgt_block];
  assign sec_we_open   = write_lock_byte[SEC_BLOCK];

  assign dbg_read_ok  = tgt_sec_byte || blk_read_open;
  assign dbg_write_ok = tgt_sec_byte || blk_we_open;
  // Erase of an open security page wipes the locks too
  assign dbg_erase_ok = blk_we_open;
  // Locked security page: erasing a lock byte wipes the part
  assign dbg_full_erase = tgt_sec_byte && !sec_we_open;

  // ----------------------------------------
  // Firmware permissions
  // ----------------------------------------
  logic fw_zone_ok;
  logic fw_flash_read_ok;
  logic fw_write_ok;
  logic fw_erase_ok;
  logic scr_access;
  logic scr_erase_all;

  // Lock bytes play no part here
  // Upper code may not reach into the lower partition
  assign fw_zone_ok = exe_below || !tgt_below;
  assign fw_flash_read_ok = fw_zone_ok;
  assign fw_write_ok = fw_zone_ok && global_write_permit;
  // The security page can never be erased by software
  assign fw_erase_ok = fw_write_ok && !tgt_sec_page;

  assign scr_access    = scratchpad_select;
  assign scr_erase_all = req_addr == SCR_ERASE_ADDR;

  // ----------------------------------------
  // Command selection
  // ----------------------------------------
  fg_cmd_type cmd_d;
  logic       ok_d;
  logic       scratch_d;
  logic       read_req;

  assign read_req = req_op == OP_READ || req_op == OP_FETCH;

  always_comb begin
    cmd_d     = CMD_NONE;
    ok_d      = 1'b0;
    scratch_d = 1'b0;
    if (req_src == SRC_DEBUG) begin
      unique case (req_op)
        OP_FETCH,
        OP_READ: begin
          ok_d  = dbg_read_ok && !tgt_reserved;
          cmd_d = CMD_READ;
        end
        OP_WRITE: begin
          ok_d  = dbg_write_ok && !tgt_reserved;
          cmd_d = CMD_WRITE;
        end
        OP_ERASE: begin
          if (dbg_full_erase) begin
            ok_d  = 1'b1;
            cmd_d = CMD_FULL_ERASE;
          end else begin
            ok_d  = dbg_erase_ok && !tgt_reserved;
            cmd_d = CMD_PAGE_ERASE;
          end
        end
      endcase
    end else begin
      unique case (req_op)
        // Branches into the lower partition stay legal
        OP_FETCH: begin
          ok_d  = 1'b1;
          cmd_d = CMD_READ;
        end
        OP_READ: begin
          scratch_d = scr_access;
          ok_d  = scr_access ||
                  (fw_flash_read_ok && !tgt_reserved);
          cmd_d = CMD_READ;
        end
        OP_WRITE: begin
          scratch_d = scr_access && program_write_enable;
          if (!program_write_enable) begin
            ok_d  = 1'b1;
            cmd_d = CMD_XRAM_WRITE;
          end else if (scr_access) begin
            ok_d  = global_write_permit;
            cmd_d = !page_erase_enable ? CMD_WRITE :
                    scr_erase_all      ? CMD_SCRATCH_ERASE :
                                         CMD_PAGE_ERASE;
          end else if (page_erase_enable) begin
            // Data byte is ignored for an erase
            ok_d  = fw_erase_ok && !tgt_reserved;
            cmd_d = CMD_PAGE_ERASE;
          end else begin
            ok_d  = fw_write_ok && !tgt_reserved;
            cmd_d = CMD_WRITE;
          end
        end
        // Software erases only through a data write
        OP_ERASE: begin
          ok_d  = 1'b0;
          cmd_d = CMD_NONE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Read answer
  // ----------------------------------------
  logic deny_read;

  assign deny_read = req_valid && read_req && !ok_d;

  // Refused reads answer with zero unless flash data returns in the same cycle
  assign resp_valid_d = deny_read || flash_rvalid;
  assign resp_data_d  = flash_rvalid ? flash_rdata :
                        {DATA_W{1'b0}};

  // ----------------------------------------
  // Register file flops
  // ----------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      timing_we_q    <= TIMING_WE_RST;
      prog_store_q   <= PROG_STORE_RST;
      limit_byte_q   <= ACCESS_LIMIT_RST;
      limit_locked_q <= 1'b0;
      sfr_rdata_q    <= 8'h00;
    end else begin
      timing_we_q    <= timing_we_d;
      prog_store_q   <= prog_store_d;
      limit_byte_q   <= limit_byte_d;
      limit_locked_q <= limit_locked_d;
      sfr_rdata_q    <= sfr_rdata_d;
    end
  end

  // ----------------------------------------
  // Answer flops
  // ----------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      req_done_q   <= 1'b0;
      req_denied_q <= 1'b0;
      resp_valid_q <= 1'b0;
      resp_data_q  <= {DATA_W{1'b0}};
    end else begin
      req_done_q   <= req_valid && ok_d;
      req_denied_q <= req_valid && !ok_d;
      resp_valid_q <= resp_valid_d;
      resp_data_q  <= resp_data_d;
    end
  end

  // ----------------------------------------
  // Command flops
  // ----------------------------------------
  // A refused request never reaches the array
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_valid_q   <= 1'b0;
      cmd_q         <= CMD_NONE;
      cmd_addr_q    <= {ADDR_W{1'b0}};
      cmd_wdata_q   <= {DATA_W{1'b0}};
      cmd_scratch_q <= 1'b0;
    end else begin
      cmd_valid_q <= req_valid && ok_d;
      if (req_valid && ok_d) begin
        cmd_q         <= cmd_d;
        cmd_addr_q    <= req_addr;
        cmd_wdata_q   <= req_wdata;
        cmd_scratch_q <= scratch_d;
      end
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign sfr_rdata       = sfr_rdata_q;
  assign req_done        = req_done_q;
  assign req_denied      = req_denied_q;
  assign resp_valid      = resp_valid_q;
  assign resp_data       = resp_data_q;
  assign flash_cmd_valid = cmd_valid_q;
  assign flash_cmd       = cmd_q;
  assign flash_addr      = cmd_addr_q;
  assign flash_wdata     = cmd_wdata_q;
  assign flash_scratch   = cmd_scratch_q;
  // Timing code drives the array straight from its field
  assign read_time_code  = timing_we_q[RT_MSB:RT_LSB];

endmodule

// ==== include/fg_pkg.sv ====
// Operation
// - Debug port may read, write and erase any page not locked.
// - Debug port access to a locked page is refused, save for the security bytes.
// - Debug port may always read the two security bytes.
// - Debug port may always write the security bytes.
// - Erasing an unlocked security page from debug clears all locks.
// - Locked security page needs a full device erase from debug.
// - Reserved area is never read, written or erased, except by firmware fetches.
// - Security bytes never restrict firmware accesses.
// - Firmware below the limit may access all pages but may not erase the security page.
// - Firmware may never erase the security byte page.
// - Firmware may read and write the security byte page like any other page.
// - Firmware at or above the limit cannot touch pages below it, except by fetch.
// - Firmware at or above the limit may access pages above it.
// - Instruction fetches below the limit are always allowed.
// - Read time code in bits 5-4 selects the clock ceiling.
// - Bits 3-1 of the timing register read zero, written zero.
// - Bit 0 of the timing register permits firmware writes, erases.
// - Scratchpad select redirects firmware accesses; 0x400 erases both.
// - Page erase enable turns data writes into page erases.
// - Program write enable routes data writes to flash, else RAM.
// - Access limit is 17 bits: limit byte above nine zero bits.
// - Access limit byte takes only its first write after reset.
// - Security bit zero locks its block for the debug port.
package fg_pkg;

  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;

  // Register offsets
  localparam logic [7:0] TIMING_WE_OFS    = 8'hB7;
  localparam logic [7:0] PROG_STORE_OFS   = 8'h8F;
  localparam logic [7:0] ACCESS_LIMIT_OFS = 8'hB5;

  // Field positions
  localparam int RT_LSB  = 4;
  localparam int RT_MSB  = 5;
  localparam int GWP_BIT = 0;
  localparam int SPS_BIT = 2;
  localparam int PEE_BIT = 1;
  localparam int PWE_BIT = 0;

  // Reset values and readable bits
  localparam logic [7:0] TIMING_WE_RST    = 8'h00;
  localparam logic [7:0] PROG_STORE_RST   = 8'h00;
  localparam logic [7:0] ACCESS_LIMIT_RST = 8'h00;
  localparam logic [7:0] TIMING_WE_MASK   = 8'h31;
  localparam logic [7:0] PROG_STORE_MASK  = 8'h07;

  // Flash geometry
  localparam int LIMIT_SHIFT = 9;
  localparam int PAGE_LSB    = 10;
  localparam int BLOCK_LSB   = 14;
  localparam logic [ADDR_W-1:0] SEC_WLOCK_ADDR = 17'h1FBFE;
  localparam logic [ADDR_W-1:0] SEC_RLOCK_ADDR = 17'h1FBFF;
  localparam logic [ADDR_W-1:0] RSV_BASE       = 17'h1FC00;
  localparam logic [ADDR_W-1:0] SCR_ERASE_ADDR = 17'h00400;
  localparam logic [2:0] SEC_BLOCK = SEC_WLOCK_ADDR[ADDR_W-1:BLOCK_LSB];

  typedef enum logic {SRC_DEBUG, SRC_FW} fg_src_type;

  typedef enum logic [1:0] {
    OP_FETCH,
    OP_READ,
    OP_WRITE,
    OP_ERASE
  } fg_op_type;

  typedef enum logic [2:0] {
    CMD_NONE,
    CMD_READ,
    CMD_WRITE,
    CMD_PAGE_ERASE,
    CMD_FULL_ERASE,
    CMD_SCRATCH_ERASE,
    CMD_XRAM_WRITE
  } fg_cmd_type;

endpackage

// ==== src/fg_addr_class.sv ====
`timescale 1ns/10ps
module fg_addr_class
  import fg_pkg::*;
#(
  parameter int AW = ADDR_W
) (
  // Address under test
  input  wire logic [AW-1:0] addr,
  input  wire logic [AW-1:0] limit_addr,
  // Classification
  output logic [2:0]         block,
  output logic               sec_page,
  output logic               sec_byte,
  output logic               reserved,
  output logic               below_limit
);

  // ----------------------------------------
  // Page and region decode
  // ----------------------------------------
  assign block       = addr[AW-1:BLOCK_LSB];
  assign sec_page    = addr[AW-1:PAGE_LSB] ==
                       SEC_WLOCK_ADDR[AW-1:PAGE_LSB];
  // Both lock bytes share every bit but the lowest
  assign sec_byte    = addr[AW-1:1] == SEC_RLOCK_ADDR[AW-1:1];
  assign reserved    = addr >= RSV_BASE;
  assign below_limit = addr < limit_addr;

endmodule

// ==== sim/fg_guard_monitor.sv ====
`timescale 1ns/10ps
// --------------------------------------------------
// Port-level checks of the access guard
// --------------------------------------------------
module fg_guard_monitor
  import fg_pkg::*;
(
  // Clock and reset
  input wire logic              mclk,
  input wire logic              reset_n,
  // Register port
  input wire logic [7:0]        sfr_addr,
  input wire logic              sfr_wr_en,
  input wire logic [7:0]        sfr_wdata,
  // Requests
  input wire logic              req_valid,
  input wire fg_src_type        req_src,
  input wire fg_op_type         req_op,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [7:0]        read_lock_byte,
  // Answers
  input wire logic              req_done,
  input wire logic              req_denied,
  input wire logic              resp_valid,
  input wire logic [DATA_W-1:0] resp_data,
  input wire logic              flash_cmd_valid,
  input wire logic [ADDR_W-1:0] flash_addr,
  input wire logic [1:0]        read_time_code
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  wire logic       dbg_req = req_valid && req_src == SRC_DEBUG;
  wire logic       fw_req  = req_valid && req_src == SRC_FW;
  wire logic [1:0] wr_rt   = sfr_wdata[RT_MSB:RT_LSB];
  // Both security bytes differ only in bit 0
  wire logic sec_hit =
    req_addr[ADDR_W-1:1] == SEC_WLOCK_ADDR[ADDR_W-1:1];
  wire logic rd_open = read_lock_byte[req_addr[ADDR_W-1:BLOCK_LSB]];

  a_answer_one_cycle: assert property (
    req_valid |=> req_done != req_denied)
    else $error("request not answered exactly once");
  a_no_stray_answer: assert property (
    !req_valid |=> !req_done && !req_denied)
    else $error("answer without a request");
  a_cmd_only_grant: assert property (
    flash_cmd_valid == req_done)
    else $error("flash command not paired with a grant");
  a_addr_held: assert property (
    !req_done |-> $stable(flash_addr))
    else $error("flash address moved without a grant");
  a_debug_lock: assert property (
    dbg_req && req_op == OP_READ && !sec_hit && !rd_open |=> req_denied)
    else $error("locked debug read granted");
  a_lock_bytes_read: assert property (
    dbg_req && req_op == OP_READ && sec_hit |=> req_done)
    else $error("debug read of security byte refused");
  a_reserved_shut: assert property (
    dbg_req && req_addr >= RSV_BASE && req_op != OP_ERASE |=> req_denied)
    else $error("reserved area access granted");
  a_fw_erase_refused: assert property (
    fw_req && req_op == OP_ERASE |=> req_denied)
    else $error("firmware direct erase granted");
  a_fetch_free: assert property (
    fw_req && req_op == OP_FETCH |=> req_done)
    else $error("instruction fetch refused");
  a_read_time_set: assert property (
    sfr_wr_en && sfr_addr == TIMING_WE_OFS |=> read_time_code == $past(wr_rt))
    else $error("read time code not taken from write");
  a_denied_read_zero: assert property (
    req_valid && req_op == OP_READ ##1 req_denied |->
      resp_valid && resp_data == 8'h00)
    else $error("refused read leaked data");
endmodule

// ==== sim/fg_flash_model.sv ====
`timescale 1ns/10ps
// --------------------------------------------------
// Flash array answering read commands
// --------------------------------------------------
module fg_flash_model
  import fg_pkg::*;
(
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              reset_n,
  // Command from the guard
  input  wire logic              flash_cmd_valid,
  input  wire fg_cmd_type        flash_cmd,
  input  wire logic [ADDR_W-1:0] flash_addr,
  // Read return
  output logic                   flash_rvalid,
  output logic      [7:0]        flash_rdata
);
  wire logic rd_go = flash_cmd_valid && flash_cmd == CMD_READ;

  // Idle data toggles so stale bytes never pass for an answer
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      flash_rvalid <= 1'b0;
      flash_rdata  <= 8'h00;
    end else begin
      flash_rvalid <= rd_go;
      flash_rdata  <= rd_go ? (flash_addr[7:0] ^ 8'h5A) : ~flash_rdata;
    end
  end
endmodule

// ==== sim/fg_flash_access_guard_test.sv ====
`timescale 1ns/10ps
module fg_flash_access_guard_test
  import fg_pkg::*;
;
  logic              mclk = 1'b0;
  logic              reset_n, sfr_wr_en, sfr_rd_en, req_valid;
  logic [7:0]        sfr_addr, sfr_wdata, sfr_rdata, flash_rdata;
  logic [7:0]        read_lock_byte, write_lock_byte;
  fg_src_type        req_src;
  fg_op_type         req_op;
  fg_cmd_type        flash_cmd;
  logic [ADDR_W-1:0] req_addr, req_exec_addr, flash_addr;
  logic [7:0]        req_wdata, resp_data, flash_wdata;
  logic              flash_rvalid, req_done, req_denied, resp_valid;
  logic              flash_cmd_valid, flash_scratch;
  logic [1:0]        read_time_code;
  int                errors, samples_checked;

  fg_flash_access_guard dut (.mclk(mclk), .reset_n(reset_n),
    .sfr_addr(sfr_addr), .sfr_wr_en(sfr_wr_en), .sfr_rd_en(sfr_rd_en),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .req_valid(req_valid),
    .req_src(req_src), .req_op(req_op), .req_addr(req_addr),
    .req_exec_addr(req_exec_addr), .req_wdata(req_wdata),
    .read_lock_byte(read_lock_byte), .write_lock_byte(write_lock_byte),
    .flash_rvalid(flash_rvalid), .flash_rdata(flash_rdata),
    .req_done(req_done), .req_denied(req_denied), .resp_valid(resp_valid),
    .resp_data(resp_data), .flash_cmd_valid(flash_cmd_valid),
    .flash_cmd(flash_cmd), .flash_addr(flash_addr),
    .flash_wdata(flash_wdata), .flash_scratch(flash_scratch),
    .read_time_code(read_time_code));

  fg_flash_model model (.mclk(mclk), .reset_n(reset_n),
    .flash_cmd_valid(flash_cmd_valid), .flash_cmd(flash_cmd),
    .flash_addr(flash_addr), .flash_rvalid(flash_rvalid),
    .flash_rdata(flash_rdata));

  always #50 mclk = ~mclk;

  // --------------------------------------------------
  // Compare and access tasks
  // --------------------------------------------------
  task automatic check_val(string n, logic [16:0] e, logic [16:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic check_cmd(string n, fg_cmd_type e, fg_cmd_type g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %s seen %s", n, e.name, g.name);
    end
  endtask

  task automatic sfr_wr(logic [7:0] a, logic [7:0] d);
    sfr_addr  = a;
    sfr_wdata = d;
    sfr_wr_en = 1'b1;
    @(negedge mclk);
    sfr_wr_en = 1'b0;
    // Idle edge so a following call never re-raises a strobe at once
    @(negedge mclk);
  endtask

  task automatic sfr_rd(logic [7:0] a, logic [7:0] e);
    sfr_addr  = a;
    sfr_rd_en = 1'b1;
    @(negedge mclk);
    sfr_rd_en = 1'b0;
    check_val("register read", e, sfr_rdata);
    @(negedge mclk);
  endtask

  // CMD_NONE as the expected command means a refusal
  task automatic req(fg_src_type s, fg_op_type o, logic [16:0] a,
                     logic [16:0] x, fg_cmd_type c);
    int n;
    req_src       = s;
    req_op        = o;
    req_addr      = a;
    req_exec_addr = x;
    req_wdata     = a[7:0] ^ 8'h3C;
    req_valid     = 1'b1;
    @(negedge mclk);
    req_valid = 1'b0;
    check_val("granted", c != CMD_NONE, req_done);
    check_val("refused", c == CMD_NONE, req_denied);
    check_val("command valid", c != CMD_NONE, flash_cmd_valid);
    if (c == CMD_NONE && o inside {OP_READ, OP_FETCH})
      check_val("refused read", 9'h100, {resp_valid, resp_data});
    if (c != CMD_NONE) begin
      check_cmd("command", c, flash_cmd);
      check_val("command address", a, flash_addr);
    end
    if (c == CMD_WRITE)
      check_val("write data", a[7:0] ^ 8'h3C, flash_wdata);
    if (c == CMD_READ) begin
      n = 0;
      while (resp_valid !== 1'b1 && n < 8) begin
        @(negedge mclk);
        n++;
      end
      check_val("read data", {1'b1, a[7:0] ^ 8'h5A},
                {resp_valid, resp_data});
    end
    @(negedge mclk);
  endtask

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // --------------------------------------------------
  // Test sequence
  // --------------------------------------------------
  initial begin
    {reset_n, sfr_wr_en, sfr_rd_en, req_valid} = '0;
    {sfr_addr, sfr_wdata, req_wdata, req_addr, req_exec_addr} = '0;
    req_src = SRC_DEBUG;
    req_op = OP_READ;
    read_lock_byte = 8'hFE;
    write_lock_byte = 8'hFD;
    repeat (8) @(negedge mclk);
    reset_n = 1'b1;
    sfr_rd(TIMING_WE_OFS, 8'h00);
    sfr_rd(PROG_STORE_OFS, 8'h00);
    sfr_wr(ACCESS_LIMIT_OFS, 8'h80);
    sfr_wr(ACCESS_LIMIT_OFS, 8'h00);
    sfr_rd(ACCESS_LIMIT_OFS, 8'h80);
    for (int i = 0; i < 4; i++) begin
      sfr_wr(TIMING_WE_OFS, {2'b11, i[1:0], 4'h1});
      check_val("read time", i[1:0], read_time_code);
      sfr_rd(TIMING_WE_OFS, {2'b00, i[1:0], 4'h1});
    end
    sfr_wr(PROG_STORE_OFS, 8'hFF);
    sfr_rd(PROG_STORE_OFS, 8'h07);
    sfr_wr(8'h80, 8'hFF);
    sfr_rd(8'h80, 8'h00);
    req(SRC_DEBUG, OP_READ, 17'h00010, 17'h0, CMD_NONE);
    req(SRC_DEBUG, OP_READ, 17'h04010, 17'h0, CMD_READ);
    req(SRC_DEBUG, OP_WRITE, 17'h04010, 17'h0, CMD_NONE);
    req(SRC_DEBUG, OP_WRITE, 17'h00010, 17'h0, CMD_WRITE);
    req(SRC_DEBUG, OP_ERASE, 17'h08000, 17'h0, CMD_PAGE_ERASE);
    req(SRC_DEBUG, OP_ERASE, SEC_RLOCK_ADDR, 17'h0, CMD_PAGE_ERASE);
    req(SRC_DEBUG, OP_READ, RSV_BASE, 17'h0, CMD_NONE);
    req(SRC_DEBUG, OP_ERASE, RSV_BASE, 17'h0, CMD_NONE);
    read_lock_byte = 8'h7E;
    write_lock_byte = 8'h7D;
    req(SRC_DEBUG, OP_READ, SEC_RLOCK_ADDR, 17'h0, CMD_READ);
    req(SRC_DEBUG, OP_WRITE, SEC_WLOCK_ADDR, 17'h0, CMD_WRITE);
    req(SRC_DEBUG, OP_ERASE, SEC_WLOCK_ADDR, 17'h0, CMD_FULL_ERASE);
    req(SRC_DEBUG, OP_ERASE, 17'h1F800, 17'h0, CMD_NONE);
    sfr_wr(PROG_STORE_OFS, 8'h01);
    req(SRC_FW, OP_READ, 17'h00010, 17'h0, CMD_READ);
    req(SRC_FW, OP_WRITE, SEC_WLOCK_ADDR, 17'h0, CMD_WRITE);
    req(SRC_FW, OP_READ, SEC_RLOCK_ADDR, 17'h10000, CMD_READ);
    req(SRC_FW, OP_READ, 17'h00100, 17'h10000, CMD_NONE);
    req(SRC_FW, OP_WRITE, 17'h0FE00, 17'h10000, CMD_NONE);
    req(SRC_FW, OP_READ, 17'h10000, 17'h10000, CMD_READ);
    req(SRC_FW, OP_FETCH, 17'h00100, 17'h10000, CMD_READ);
    req(SRC_FW, OP_READ, 17'h00100, 17'h0FFFF, CMD_READ);
    req(SRC_FW, OP_READ, RSV_BASE, 17'h0, CMD_NONE);
    req(SRC_FW, OP_ERASE, 17'h00800, 17'h0, CMD_NONE);
    // Read time drops from 3 to 0; cache is assumed quiet already
    sfr_wr(TIMING_WE_OFS, 8'h00);
    req(SRC_FW, OP_WRITE, 17'h00800, 17'h0, CMD_NONE);
    sfr_wr(TIMING_WE_OFS, 8'h01);
    sfr_wr(PROG_STORE_OFS, 8'h03);
    req(SRC_FW, OP_WRITE, 17'h00800, 17'h0, CMD_PAGE_ERASE);
    req(SRC_FW, OP_WRITE, 17'h1F800, 17'h0, CMD_NONE);
    // Program a byte into the page erased just before
    sfr_wr(PROG_STORE_OFS, 8'h01);
    req(SRC_FW, OP_WRITE, 17'h00810, 17'h0, CMD_WRITE);
    check_val("scratch", 1'b0, flash_scratch);
    sfr_wr(PROG_STORE_OFS, 8'h00);
    req(SRC_FW, OP_WRITE, 17'h00800, 17'h0, CMD_XRAM_WRITE);
    sfr_wr(PROG_STORE_OFS, 8'h05);
    req(SRC_FW, OP_READ, 17'h00010, 17'h0, CMD_READ);
    check_val("scratch", 1'b1, flash_scratch);
    req(SRC_FW, OP_WRITE, 17'h00010, 17'h0, CMD_WRITE);
    check_val("scratch", 1'b1, flash_scratch);
    sfr_wr(PROG_STORE_OFS, 8'h07);
    req(SRC_FW, OP_WRITE, SCR_ERASE_ADDR, 17'h0, CMD_SCRATCH_ERASE);
    // Second reset must re-arm the one-shot limit byte
    reset_n = 1'b0;
    @(negedge mclk);
    reset_n = 1'b1;
    check_val("time after reset", 2'b00, read_time_code);
    sfr_wr(ACCESS_LIMIT_OFS, 8'h00);
    sfr_wr(ACCESS_LIMIT_OFS, 8'h80);
    req(SRC_FW, OP_READ, 17'h00100, 17'h10000, CMD_READ);
    complete_run;
  end

  // Whole sequence needs under 200 cycles
  initial begin
    repeat (3000) @(posedge mclk);
    errors++;
    complete_run;
  end
endmodule

bind fg_flash_access_guard fg_guard_monitor u_mon (.mclk(mclk),
  .reset_n(reset_n), .sfr_addr(sfr_addr), .sfr_wr_en(sfr_wr_en),
  .sfr_wdata(sfr_wdata), .req_valid(req_valid), .req_src(req_src),
  .req_op(req_op), .req_addr(req_addr), .read_lock_byte(read_lock_byte),
  .req_done(req_done), .req_denied(req_denied), .resp_valid(resp_valid),
  .resp_data(resp_data), .flash_cmd_valid(flash_cmd_valid),
  .flash_addr(flash_addr), .read_time_code(read_time_code));
